// file: shared/roc_pkg.sv
// Purpose: constants and state types of the relay output conditioner
// Assumes: 250 MHz clk_sys, 32-bit Avalon-MM register bus
// Notes:   source codes index one condition vector in the top
`default_nettype none
package roc_pkg;
  localparam int          ADDR_W   = 5;
  localparam int          SRC_W    = 4;
  localparam int          DLY_W    = 16;
  localparam int          HOLD_W   = 14;
  localparam int          N_GEN    = 8;
  localparam int          TICK_W   = 18;
  // Source codes; relay one stops at the last generic code
  localparam logic [3:0]  SRC_NONE       = 4'h0;
  localparam logic [3:0]  SRC_FAULT_FREE = 4'h1;
  localparam logic [3:0]  SRC_RUNNING    = 4'h2;
  localparam logic [3:0]  SRC_GEN_BASE   = 4'h3;
  localparam logic [3:0]  SRC_LINE       = 4'hB;
  localparam logic [3:0]  SRC_OCC        = 4'hC;
  localparam logic [3:0]  SRC_PRE        = 4'hD;
  localparam logic [3:0]  SRC_DAMPER     = 4'hE;
  localparam logic [15:0] DLY_MAX  = 16'hEA60;
  localparam logic [13:0] HOLD_MAX = 14'h270F;
  // Byte offsets
  localparam logic [4:0]  OFS_R1_CTRL = 5'h00;
  localparam logic [4:0]  OFS_R1_DLY  = 5'h04;
  localparam logic [4:0]  OFS_R1_HOLD = 5'h08;
  localparam logic [4:0]  OFS_R2_CTRL = 5'h0C;
  localparam logic [4:0]  OFS_R2_DLY  = 5'h10;
  localparam logic [4:0]  OFS_R2_HOLD = 5'h14;
  localparam logic [4:0]  OFS_STATUS  = 5'h18;
  localparam int          CTRL_SRC_LSB  = 0;
  localparam int          CTRL_POL_BIT  = 8;
  localparam int          STAT_OUT_LSB  = 0;
  localparam int          STAT_COND_LSB = 2;
  localparam int          STAT_PEND_LSB = 4;
  localparam logic [3:0]  RST_SRC1 = SRC_NONE;
  localparam logic [3:0]  RST_SRC2 = SRC_RUNNING;
  localparam int          MS_NS    = 1000000;
  localparam int          CLK_NS   = 4;
  localparam int          TICK_CYCLES_DEF = MS_NS / CLK_NS;

  typedef struct packed {
    logic              st;
    logic              out;
    logic              pend;
    logic [DLY_W-1:0]  cnt;
  } roc_chan_t;

  typedef struct packed {
    logic              ack;
    logic [31:0]       rdata;
    logic [TICK_W-1:0] tick_cnt;
    logic              tick;
    logic [SRC_W-1:0]  src1;
    logic [SRC_W-1:0]  src2;
    logic              neg1;
    logic              neg2;
    logic [DLY_W-1:0]  dly1;
    logic [DLY_W-1:0]  dly2;
    logic [HOLD_W-1:0] hold1;
    logic [HOLD_W-1:0] hold2;
  } roc_top_t;

  localparam roc_chan_t CHAN_RST = '{st: 1'b0, out: 1'b0, pend: 1'b0, cnt: '0};
  localparam roc_top_t  TOP_RST  = '{ack: 1'b0, rdata: '0, tick_cnt: '0, tick: 1'b0,
                                     src1: RST_SRC1, src2: RST_SRC2, neg1: 1'b0,
                                     neg2: 1'b0, dly1: '0, dly2: '0, hold1: '0,
                                     hold2: '0};
endpackage
`default_nettype wire

// file: src/roc_channel.sv
// Purpose: one relay: turn-on delay, holding time, polarity
// Assumes: tick is a one-cycle pulse per millisecond
// Notes:   delay and hold arrive already forced by the top
`timescale 1ns/1ps
`default_nettype none
module roc_channel
  import roc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              tick,
  input  wire logic              cond_in,
  input  wire logic [DLY_W-1:0]  delay_ms,
  input  wire logic [HOLD_W-1:0] hold_ms,
  input  wire logic              invert,
  output logic                   relay_out,
  output logic                   pending
);
  roc_chan_t r_q;
  roc_chan_t r_d;
  logic [DLY_W-1:0] limit;

  always_comb
  begin
    r_d   = r_q;
    limit = r_q.st ? {2'b00, hold_ms} : delay_ms;
    if (cond_in == r_q.st)
    begin
      r_d.cnt = '0; // Reverted before expiry: pending change dropped [RULE13]
    end
    // Full limit of whole ms after the first tick, so never early [RULE1] [RULE2]
    else if (limit == '0 || r_q.cnt > limit)
    begin
      r_d.st  = cond_in;
      r_d.cnt = '0;
    end
    else if (tick)
    begin
      r_d.cnt = r_q.cnt + 16'h0001;
    end
    r_d.out  = r_d.st ^ invert; // [RULE3]
    r_d.pend = cond_in != r_d.st;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      r_q <= CHAN_RST;
    else
      r_q <= r_d;
  end

  assign relay_out = r_q.out;
  assign pending   = r_q.pend;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_delay_respected: assert property ($rose(r_q.st) |-> // [RULE1]
    $past(delay_ms) == '0 || $past(r_q.cnt) > $past(delay_ms))
    else $error("relay closed before its turn-on delay");
  chk_hold_respected: assert property ($fell(r_q.st) |-> // [RULE2]
    $past(hold_ms) == '0 || $past(r_q.cnt) > {2'b00, $past(hold_ms)})
    else $error("relay released before its holding time");
  chk_revert_cancels: assert property ((cond_in == r_q.st) |=> // [RULE13]
    $stable(r_q.st) && r_q.cnt == '0)
    else $error("reverted condition still changed the relay");
  chk_polarity_map: assert property (##1 relay_out == (r_q.st ^ $past(invert))) // [RULE3]
    else $error("relay output does not follow polarity");
endmodule
`default_nettype wire

// file: src/roc_top.sv
// Purpose: two relay outputs with source select, delay, hold, polarity
// Assumes: condition inputs synchronous to clk_sys; Avalon-MM slave, one wait state
// Notes:   millisecond tick made here from clk_sys
// How it works
// RULE1 - output closes only after turn-on delay
// RULE2 - output opens only after holding time
// RULE3 - polarity setting may invert relay output
// RULE4 - relay one fault-free: turn-on delay zero
// RULE5 - relay one fault-free: polarity forced positive
// RULE6 - fault-free on either relay: hold zero
// RULE7 - relay two adds four contactor/damper sources
// RULE8 - output contactor source drives relay two
// RULE9 - precharge source drives relay two
// RULE10 - relay two contactor sources: delay zero
// RULE11 - relay two fault/precharge/line: positive polarity
// RULE12 - reset: zero times, positive, relay two running
// RULE13 - reverted condition cancels the pending change
`timescale 1ns/1ps
`default_nettype none
module roc_top
  import roc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              fault_free,
  input  wire logic              drive_running,
  input  wire logic [N_GEN-1:0]  gen_cond,
  input  wire logic              line_contactor_source,
  input  wire logic              output_contactor_source,
  input  wire logic              precharge_contactor_source,
  input  wire logic              damper_source,
  output logic                   relay_one_out,
  output logic                   relay_two_out
);
  initial
  begin
    if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << TICK_W))
      $error("TICK_CYCLES out of range");
  end

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  roc_top_t r_q;
  roc_top_t r_d;

  logic [15:0]       src_vec;
  logic              cond1;
  logic              cond2;
  logic              req;
  logic              wr_en;
  logic [31:0]       new_word;
  logic [31:0]       rd_word;
  logic [DLY_W-1:0]  dly1_eff;
  logic [DLY_W-1:0]  dly2_eff;
  logic [HOLD_W-1:0] hold1_eff;
  logic [HOLD_W-1:0] hold2_eff;
  logic              inv1;
  logic              inv2;
  logic              pend1;
  logic              pend2;
  logic              f1;
  logic              f2;

  // Bit index equals source code; code 0 and 15 read as false
  assign src_vec = {1'b0, damper_source, precharge_contactor_source,
                    output_contactor_source, line_contactor_source,
                    gen_cond, drive_running, fault_free, 1'b0};

  assign cond1 = src_vec[r_q.src1];
  assign cond2 = src_vec[r_q.src2]; // Contactor sources feed relay two directly [RULE8] [RULE9]

  assign f1 = r_q.src1 == SRC_FAULT_FREE;
  assign f2 = r_q.src2 == SRC_FAULT_FREE;

  always_comb
  begin
    dly1_eff  = f1 ? '0 : r_q.dly1; // [RULE4]
    inv1      = f1 ? 1'b0 : r_q.neg1; // [RULE5]
    hold1_eff = f1 ? '0 : r_q.hold1; // [RULE6]
    hold2_eff = f2 ? '0 : r_q.hold2; // [RULE6]
    dly2_eff  = r_q.dly2;
    inv2      = r_q.neg2;
    case (r_q.src2)
      SRC_FAULT_FREE, SRC_PRE, SRC_LINE:
      begin
        dly2_eff = '0; // [RULE10]
        inv2     = 1'b0; // [RULE11]
      end
      SRC_OCC:
      begin
        dly2_eff = '0; // [RULE10]
      end
      default:
      begin
        dly2_eff = r_q.dly2;
      end
    endcase
  end

  // One wait state: request seen, answer on the next cycle
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~r_q.ack;
  assign wr_en           = avs_write & r_q.ack;
  assign avs_readdata    = r_q.rdata;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (avs_address)
      OFS_R1_CTRL: rd_word = 32'({r_q.neg1, 4'h0, r_q.src1});
      OFS_R1_DLY:  rd_word = 32'(r_q.dly1);
      OFS_R1_HOLD: rd_word = 32'(r_q.hold1);
      OFS_R2_CTRL: rd_word = 32'({r_q.neg2, 4'h0, r_q.src2});
      OFS_R2_DLY:  rd_word = 32'(r_q.dly2);
      OFS_R2_HOLD: rd_word = 32'(r_q.hold2);
      OFS_STATUS:  rd_word = 32'({pend2, pend1, cond2, cond1,
                                  relay_two_out, relay_one_out});
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  // Byte lanes merged over the current contents
  always_comb
  begin
    new_word = rd_word;
    for (int b = 0; b < 4; b++)
    begin
      if (avs_byteenable[b])
        new_word[8*b +: 8] = avs_writedata[8*b +: 8];
    end
  end

  always_comb
  begin
    r_d       = r_q;
    r_d.ack   = req & ~r_q.ack;
    r_d.tick  = r_q.tick_cnt == TICK_LAST;
    r_d.tick_cnt = r_d.tick ? '0 : r_q.tick_cnt + 18'h00001;
    if (req & ~r_q.ack)
      r_d.rdata = rd_word;
    if (wr_en)
    begin
      case (avs_address)
        OFS_R1_CTRL:
        begin
          r_d.neg1 = new_word[CTRL_POL_BIT];
          // Contactor and damper codes are refused for relay one [RULE7]
          if (new_word[CTRL_SRC_LSB +: SRC_W] < SRC_LINE)
            r_d.src1 = new_word[CTRL_SRC_LSB +: SRC_W];
        end
        OFS_R2_CTRL:
        begin
          r_d.neg2 = new_word[CTRL_POL_BIT];
          r_d.src2 = new_word[CTRL_SRC_LSB +: SRC_W]; // [RULE7]
        end
        OFS_R1_DLY:
          r_d.dly1 = (new_word[15:0] > DLY_MAX) ? DLY_MAX : new_word[15:0];
        OFS_R2_DLY:
          r_d.dly2 = (new_word[15:0] > DLY_MAX) ? DLY_MAX : new_word[15:0];
        OFS_R1_HOLD:
          r_d.hold1 = (new_word[15:0] > 16'(HOLD_MAX)) ? HOLD_MAX : new_word[13:0];
        OFS_R2_HOLD:
          r_d.hold2 = (new_word[15:0] > 16'(HOLD_MAX)) ? HOLD_MAX : new_word[13:0];
        default:
        begin
          r_d.ack = 1'b0;
        end
      endcase
    end
  end

  // Reset loads zero times, positive polarity, relay two on running [RULE12]
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      r_q <= TOP_RST;
    else
      r_q <= r_d;
  end

  roc_channel u_relay_one (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .tick      (r_q.tick),
    .cond_in   (cond1),
    .delay_ms  (dly1_eff),
    .hold_ms   (hold1_eff),
    .invert    (inv1),
    .relay_out (relay_one_out),
    .pending   (pend1)
  );

  roc_channel u_relay_two (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .tick      (r_q.tick),
    .cond_in   (cond2),
    .delay_ms  (dly2_eff),
    .hold_ms   (hold2_eff),
    .invert    (inv2),
    .relay_out (relay_two_out),
    .pending   (pend2)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_r1_fault_rise;
    f1 && !wr_en && $rose(cond1);
  endsequence
  sequence s_r1_fault_fall;
    f1 && !wr_en && $fell(cond1);
  endsequence
  sequence s_r2_forced_rise;
    (r_q.src2 == SRC_PRE || r_q.src2 == SRC_LINE) && !wr_en && $rose(cond2);
  endsequence

  chk_r1_fault_close: assert property (s_r1_fault_rise |=> relay_one_out) // [RULE4] [RULE5]
    else $error("relay one fault-free did not close at once");
  chk_r1_fault_open: assert property (s_r1_fault_fall |=> !relay_one_out) // [RULE6]
    else $error("relay one fault-free did not open at once");
  chk_r2_forced_pos: assert property (s_r2_forced_rise |=> relay_two_out) // [RULE10] [RULE11]
    else $error("relay two contactor source delayed or inverted");
  chk_r2_occ_nodelay: assert property ((r_q.src2 == SRC_OCC && !wr_en && !pend2 && // [RULE10]
    $rose(cond2)) |=> $changed(relay_two_out))
    else $error("output contactor source was delayed");
  chk_r2_occ_path: assert property ((r_q.src2 == SRC_OCC) |-> // [RULE8]
    cond2 == output_contactor_source)
    else $error("output contactor source not routed to relay two");
  chk_r2_pre_path: assert property ((r_q.src2 == SRC_PRE) |-> // [RULE9]
    cond2 == precharge_contactor_source)
    else $error("precharge source not routed to relay two");
  chk_r1_src_refuse: assert property ((wr_en && avs_address == OFS_R1_CTRL && // [RULE7]
    avs_byteenable[0] && avs_writedata[3:0] >= SRC_LINE) |=> $stable(r_q.src1))
    else $error("relay one took a relay-two-only source");
  chk_reset_values: assert property (disable iff (1'b0) reset |=> // [RULE12]
    r_q.dly1 == '0 && r_q.dly2 == '0 && r_q.hold1 == '0 && r_q.hold2 == '0 &&
    !r_q.neg1 && !r_q.neg2 && r_q.src2 == SRC_RUNNING)
    else $error("wrong configuration after reset");
  chk_bus_answer: assert property ((req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer later than one wait state");
endmodule
`default_nettype wire

// file: verification/roc_coil_model.sv
// Purpose: contactor hanging on the relay two coil
// Assumes: coil energised while its input is high
// Notes:   pickup delay only; drop-out is immediate, no bounce
`timescale 1ns/1ps
`default_nettype none
module roc_coil_model
#(
  parameter int PICK = 3
)
(
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic coil,
  output logic      closed
);
  int cnt;
  always_ff @(posedge clk_sys)
  begin
    if (reset || !coil)
    begin
      cnt    <= 0;
      closed <= 1'b0;
    end
    else if (cnt < PICK)
      cnt <= cnt + 1;
    else
      closed <= 1'b1;
  end
endmodule
`default_nettype wire

// file: verification/roc_top_tb.sv
// Purpose: register and relay checks of roc_top
// Assumes: TICK_CYCLES 4, so one millisecond is four clocks
// Notes:   relay levels sampled 1 ns after an edge, once flops settle
`timescale 1ns/1ps
`default_nettype none
module roc_top_tb;
  import roc_pkg::*;
  localparam logic [3:0] IDLE2 = 4'hA;
  localparam logic [3:0] ACT2  = 4'hD;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [4:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ff = 1'b0;
  logic        run = 1'b0;
  logic [7:0]  gen = '0;
  logic [3:0]  ext = '0;
  logic        r1;
  logic        r2;
  logic        closed;
  logic [31:0] rd;
  int          failures = 0;
  int          checks_done = 0;

  roc_top #(.TICK_CYCLES(4)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fault_free(ff), .drive_running(run),
    .gen_cond(gen), .line_contactor_source(ext[0]),
    .output_contactor_source(ext[1]), .precharge_contactor_source(ext[2]),
    .damper_source(ext[3]), .relay_one_out(r1), .relay_two_out(r2));

  roc_coil_model i_coil (.clk_sys(clk_sys), .reset(reset), .coil(r2), .closed(closed));

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int   n;
    logic w;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= b;
    avs_write      <= wr;
    avs_read       <= !wr;
    do
    begin
      @(posedge clk_sys);
      // Flops update by NBA, so these are the values this edge samples
      w  = avs_waitrequest;
      rd = avs_readdata;
      n++;
    end while (w !== 1'b0 && n < 20);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (w !== 1'b0)
    begin
      failures++;
      test_done();
    end
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(what, rd, exp);
  endtask

  task automatic at(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    at(1);
    chk("relay_one", r1, 1'b0);
    rdchk(OFS_R1_CTRL, 32'h0, "r1_ctrl");
    rdchk(OFS_R2_CTRL, 32'h2, "r2_ctrl");
    rdchk(OFS_R1_HOLD, 32'h0, "r1_hold");
    rdchk(OFS_R2_DLY, 32'h0, "r2_dly");
    rdchk(5'h1C, 32'h0, "unmapped");
    @(posedge clk_sys);
    run <= 1'b1;
    at(2);
    chk("r2_running", r2, 1'b1);
    at(4);
    chk("contactor", closed, 1'b1);
    rdchk(OFS_STATUS, 32'hA, "status");
    bus(1'b1, OFS_R1_DLY, 32'hFFFF, 4'hF);
    rdchk(OFS_R1_DLY, {16'h0, DLY_MAX}, "r1_dly_sat");
    bus(1'b1, OFS_R1_HOLD, 32'hFFFF, 4'hF);
    rdchk(OFS_R1_HOLD, {18'h0, HOLD_MAX}, "r1_hold_sat");
    bus(1'b1, OFS_R1_DLY, 32'h1234, 4'hF);
    bus(1'b1, OFS_R1_DLY, 32'hFF00, 4'h1);
    rdchk(OFS_R1_DLY, 32'h1200, "byte_merge");
    bus(1'b1, OFS_R1_DLY, 32'h3, 4'hF);
    bus(1'b1, OFS_R1_HOLD, 32'h2, 4'hF);
    bus(1'b1, OFS_R1_CTRL, {28'h0, SRC_GEN_BASE}, 4'hF);
    // 3 ms delay lands between 12 and 18 clocks
    @(posedge clk_sys);
    gen[0] <= 1'b1;
    at(10);
    chk("r1_on_early", r1, 1'b0);
    at(10);
    chk("r1_on_late", r1, 1'b1);
    @(posedge clk_sys);
    gen[0] <= 1'b0;
    at(6);
    chk("r1_off_early", r1, 1'b1);
    at(10);
    chk("r1_off_late", r1, 1'b0);
    @(posedge clk_sys);
    gen[0] <= 1'b1;
    at(4);
    @(posedge clk_sys);
    gen[0] <= 1'b0;
    at(24);
    chk("r1_cancel", r1, 1'b0);
    bus(1'b1, OFS_R1_CTRL, 32'h103, 4'hF);
    at(2);
    chk("r1_negative", r1, 1'b1);
    bus(1'b1, OFS_R1_CTRL, 32'h10B, 4'hF);
    rdchk(OFS_R1_CTRL, 32'h103, "r1_src_keep");
    bus(1'b1, OFS_R1_CTRL, 32'h101, 4'hF);
    at(20);
    chk("r1_ff_idle", r1, 1'b0);
    @(posedge clk_sys);
    ff <= 1'b1;
    at(2);
    chk("r1_ff_on", r1, 1'b1);
    @(posedge clk_sys);
    ff <= 1'b0;
    at(2);
    chk("r1_ff_off", r1, 1'b0);
    bus(1'b1, OFS_R2_DLY, 32'h3, 4'hF);
    bus(1'b1, OFS_R2_HOLD, 32'h2, 4'hF);
    bus(1'b1, OFS_R2_CTRL, 32'h101, 4'hF);
    at(20);
    @(posedge clk_sys);
    ff <= 1'b1;
    at(2);
    chk("r2_ff_on", r2, 1'b1);
    @(posedge clk_sys);
    ff <= 1'b0;
    at(2);
    chk("r2_ff_off", r2, 1'b0);
    // Negative polarity, 3 ms delay, 2 ms hold written for every extra source; only the damper keeps all three
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, OFS_R2_CTRL, 32'h10B + i, 4'hF);
      at(20);
      chk("r2_idle", r2, {31'h0, IDLE2[i]});
      @(posedge clk_sys);
      ext[i] <= 1'b1;
      at(2);
      chk("r2_active", r2, {31'h0, ACT2[i]});
      @(posedge clk_sys);
      ext[i] <= 1'b0;
    end
    test_done();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
